/* irsc_pkg.sv */
// Functional notes
// - Configuration write restarts conversion unless powering down
// - Reset bit write resets everything, self-clears
// - Run bit: 0 power-down, 1 converting
// - Rate code selects averages per result
// - Rate code selects conversion period and idle
// - Enabled alert pin follows cumulative flag, active low
// - Alert enable shared by configuration and mask
// - Cumulative flag ORs enabled flags, mode-dependent clear
// - Transient correction enable bit
// - Mode bit picks latched or compare flags
// - Object result 14-bit signed in bits 15:2
// - Invalid bit follows math engine each conversion
// - Latched limit, invalid and over-range flags clear only on status read
// - Compare flags re-evaluated every conversion end
// - Conversion ready always latched, three clear causes
// - Object high flag on result above limit
// - Object low flag; zero in compare mode
// - Die high flag; compare clears when die drops below object low limit
// - Die low flag; zero in compare mode
// - Data invalid flag on math error/voltage range
// - Memory check flag clears on clean check
// - Sensor over range flag
package irsc_pkg;
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	localparam logic [7:0] ADDR_VSENSOR = 8'h00;
	localparam logic [7:0] ADDR_TDIE    = 8'h01;
	localparam logic [7:0] ADDR_CFG     = 8'h02;
	localparam logic [7:0] ADDR_OBJECT_TEMPERATURE_RESULT    = 8'h03;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_MASK    = 8'h05;

	localparam logic [15:0] CFG_RST_VAL  = 16'h1440;
	localparam int          CFG_RST_BIT  = 15;
	localparam int          CFG_RUN_BIT  = 12;
	localparam int          CFG_RATE_LSB = 9;
	localparam int          CFG_AEN_BIT  = 8;
	localparam int          CFG_TC_BIT   = 6;
	localparam int          CFG_COMP_BIT = 5;
	localparam int          MASK_AEN_BIT = 15;
	localparam int          MASK_EN_LSB  = 8;

	typedef struct packed {
		logic [15:0] vsensor;
		logic [13:0] tdie;
		logic [13:0] object_temperature_result;
		logic        math_invalid;
		logic        sensor_ovr;
	} irsc_sample_s;

	typedef struct packed {
		logic [9:0] obj_hi;
		logic [9:0] obj_lo;
		logic [9:0] die_hi;
		logic [9:0] die_lo;
	} irsc_limits_s;

	typedef struct packed {
		logic obj_hi;
		logic obj_lo;
		logic die_hi;
		logic die_lo;
		logic die_below_obj_lo;
		logic invalid;
		logic over_range;
	} irsc_hits_s;

	// Order matches status bits 14 down to 7
	typedef struct packed {
		logic conversion_done_flag;
		logic object_high_flag;
		logic object_low_flag;
		logic die_high_flag;
		logic die_low_flag;
		logic data_invalid_flag;
		logic memory_check_failed_flag;
		logic sensor_over_range_flag;
	} irsc_flags_s;

	function automatic logic [4:0] avg_of(input logic [2:0] rate);
		case (rate)
			3'h0, 3'h5: avg_of = 5'h01;
			3'h1, 3'h6: avg_of = 5'h02;
			3'h3:       avg_of = 5'h08;
			3'h4:       avg_of = 5'h10;
			default:    avg_of = 5'h04;
		endcase
	endfunction

	// Periods and idle shares in ms
	function automatic logic [31:0] period_ms(input logic [2:0] rate);
		case (rate)
			3'h0:       period_ms = 32'd260;
			3'h1:       period_ms = 32'd510;
			3'h2:       period_ms = 32'd1010;
			3'h3:       period_ms = 32'd2010;
			3'h4:       period_ms = 32'd4010;
			3'h5:       period_ms = 32'd1000;
			default:    period_ms = 32'd4000;
		endcase
	endfunction

	function automatic logic [31:0] idle_ms(input logic [2:0] rate);
		case (rate)
			3'h5:       idle_ms = 32'd750;
			3'h6:       idle_ms = 32'd3500;
			3'h7:       idle_ms = 32'd3000;
			default:    idle_ms = 32'd0;
		endcase
	endfunction
endpackage

/* irsc_conv_timer.sv */
module irsc_conv_timer #(
	parameter int unsigned CYC_PER_MS = irsc_pkg::CYC_PER_MS
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_sw_rst,
	input  wire logic       i_run,
	input  wire logic       i_restart,
	input  wire logic [2:0] i_rate,
	output logic            o_done,
	output logic            o_busy
);
	import irsc_pkg::*;

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_CONV = 2'b01,
		ST_REST = 2'b10
	} irsc_tstate_e;

	irsc_tstate_e state_reg, state_next;
	logic [31:0]  cnt_reg, cnt_next;
	logic         done_next;

	wire logic [31:0] active_cyc = (period_ms(i_rate) - idle_ms(i_rate)) * CYC_PER_MS;
	wire logic [31:0] idle_cyc   = idle_ms(i_rate) * CYC_PER_MS;
	wire logic        has_idle   = (idle_cyc != 32'h0);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 32'h1;
		done_next  = 1'b0;
		case (state_reg)
			ST_OFF: begin
				cnt_next = 32'h0;
				if (i_run) state_next = ST_CONV;
			end
			ST_CONV: begin
				if (cnt_reg >= active_cyc - 32'h1) begin
					done_next  = 1'b1;
					cnt_next   = 32'h0;
					state_next = has_idle ? ST_REST : ST_CONV;
				end
			end
			ST_REST: begin
				if (cnt_reg >= idle_cyc - 32'h1) begin
					cnt_next   = 32'h0;
					state_next = ST_CONV;
				end
			end
			default: begin
				cnt_next   = 32'h0;
				state_next = ST_OFF;
			end
		endcase
		if (!i_run) begin
			state_next = ST_OFF;
			cnt_next   = 32'h0;
			done_next  = 1'b0;
		end else if (i_restart) begin
			state_next = ST_CONV;
			cnt_next   = 32'h0;
			done_next  = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_OFF;
			cnt_reg   <= 32'h0;
			o_done    <= 1'b0;
			o_busy    <= 1'b0;
		end else if (i_sw_rst) begin
			state_reg <= ST_OFF;
			cnt_reg   <= 32'h0;
			o_done    <= 1'b0;
			o_busy    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			o_done    <= done_next;
			o_busy    <= (state_next == ST_CONV);
		end
	end
endmodule // irsc_conv_timer

/* irsc_flags.sv */
module irsc_flags (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_sw_rst,
	input  wire logic                 i_eval,
	input  wire logic                 i_comp,
	input  wire logic                 i_status_rd,
	input  wire logic                 i_cfg_wr,
	input  wire logic                 i_result_rd,
	input  wire irsc_pkg::irsc_hits_s i_hits,
	input  wire logic                 i_mem_done,
	input  wire logic                 i_mem_fail,
	input  wire logic [7:0]           i_en,
	output irsc_pkg::irsc_flags_s     o_flags,
	output logic                      o_cumulative_alert_flag
);
	import irsc_pkg::*;

	irsc_flags_s nx;

	// Latched: set by violation, kept until read; compare: follows result
	function automatic logic upd(input logic f, input logic hit, input logic ev, input logic cmp,
	                             input logic rd);
		upd = cmp ? (ev ? hit : f) : ((ev & hit) | (f & ~rd));
	endfunction

	wire logic lh_cmp = i_eval ? (i_hits.die_hi | (o_flags.die_high_flag & ~i_hits.die_below_obj_lo))
	                           : o_flags.die_high_flag;

	always_comb begin
		nx.conversion_done_flag = i_eval
		                        | (o_flags.conversion_done_flag & ~(i_status_rd | i_cfg_wr | i_result_rd));
		nx.object_high_flag  = upd(o_flags.object_high_flag, i_hits.obj_hi, i_eval, i_comp, i_status_rd);
		nx.object_low_flag   = i_comp ? 1'b0
		                     : upd(o_flags.object_low_flag, i_hits.obj_lo, i_eval, 1'b0, i_status_rd);
		nx.die_high_flag     = i_comp ? lh_cmp
		                     : upd(o_flags.die_high_flag, i_hits.die_hi, i_eval, 1'b0, i_status_rd);
		nx.die_low_flag      = i_comp ? 1'b0
		                     : upd(o_flags.die_low_flag, i_hits.die_lo, i_eval, 1'b0, i_status_rd);
		nx.data_invalid_flag = upd(o_flags.data_invalid_flag, i_hits.invalid | i_hits.over_range,
		                           i_eval, i_comp, i_status_rd);
		nx.memory_check_failed_flag = i_mem_done ? i_mem_fail : o_flags.memory_check_failed_flag;
		nx.sensor_over_range_flag = upd(o_flags.sensor_over_range_flag, i_hits.over_range,
		                                i_eval, i_comp, i_status_rd);
	end

	// Over-range shares the invalid flag's enable
	wire logic [7:0] en_vec  = i_en;
	wire logic       any_en  = |(en_vec & nx);
	wire logic       alrt_nx = i_comp ? (i_eval ? any_en : (o_cumulative_alert_flag | any_en))
	                                  : (any_en | (o_cumulative_alert_flag & ~i_status_rd));

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_flags <= '0;
			o_cumulative_alert_flag <= 1'b0;
		end else if (i_sw_rst) begin
			o_flags <= '0;
			o_cumulative_alert_flag <= 1'b0;
		end else begin
			o_flags <= nx;
			o_cumulative_alert_flag <= alrt_nx;
		end
	end
endmodule // irsc_flags

/* irsc_top.sv */
module irsc_top #(
	parameter int unsigned CYC_PER_MS = irsc_pkg::CYC_PER_MS
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic [7:0]             i_reg_addr,
	input  wire logic [15:0]            i_reg_wdata,
	input  wire irsc_pkg::irsc_sample_s i_sample,
	input  wire irsc_pkg::irsc_limits_s i_limits,
	input  wire logic                   i_mem_check_done,
	input  wire logic                   i_mem_check_fail,
	output logic [15:0]                 o_reg_rdata,
	output logic                        o_reg_rvalid,
	output logic                        o_alert_n,
	output logic                        o_converting,
	output logic                        o_conv_restart,
	output logic [4:0]                  o_avg_count,
	output logic                        o_transient_corr
);
	import irsc_pkg::*;

	// Configuration fields
	logic       run_reg;
	logic [2:0] rate_reg;
	logic       tc_reg;
	logic       comp_reg;
	logic       alert_en_reg;
	logic [6:0] mask_en_reg;

	irsc_sample_s sample_reg;
	logic         eval_reg;
	irsc_flags_s  flags;
	logic         cumulative_alert_flag;
	logic         conv_done;

	// Register access decode
	wire logic cfg_wr    = i_reg_wr & (i_reg_addr == ADDR_CFG);
	wire logic mask_wr   = i_reg_wr & (i_reg_addr == ADDR_MASK);
	wire logic status_rd = i_reg_rd & (i_reg_addr == ADDR_STATUS);
	wire logic result_rd = i_reg_rd & ((i_reg_addr == ADDR_VSENSOR) | (i_reg_addr == ADDR_TDIE)
	                                 | (i_reg_addr == ADDR_OBJECT_TEMPERATURE_RESULT));
	wire logic sw_rst    = cfg_wr & i_reg_wdata[CFG_RST_BIT];
	// Power-down writes raise no restart; the timer clears its counter once run drops
	wire logic restart   = cfg_wr & ~sw_rst & i_reg_wdata[CFG_RUN_BIT];

	wire logic [2:0] wr_rate = i_reg_wdata[CFG_RATE_LSB +: 3];

	wire logic alert_en_next = cfg_wr  ? i_reg_wdata[CFG_AEN_BIT]
	                         : mask_wr ? i_reg_wdata[MASK_AEN_BIT] : alert_en_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_reg      <= CFG_RST_VAL[CFG_RUN_BIT];
			rate_reg     <= CFG_RST_VAL[CFG_RATE_LSB +: 3];
			tc_reg       <= CFG_RST_VAL[CFG_TC_BIT];
			comp_reg     <= CFG_RST_VAL[CFG_COMP_BIT];
			alert_en_reg <= CFG_RST_VAL[CFG_AEN_BIT];
			mask_en_reg  <= 7'h00;
		end else if (sw_rst) begin
			run_reg      <= CFG_RST_VAL[CFG_RUN_BIT];
			rate_reg     <= CFG_RST_VAL[CFG_RATE_LSB +: 3];
			tc_reg       <= CFG_RST_VAL[CFG_TC_BIT];
			comp_reg     <= CFG_RST_VAL[CFG_COMP_BIT];
			alert_en_reg <= CFG_RST_VAL[CFG_AEN_BIT];
			mask_en_reg  <= 7'h00;
		end else begin
			alert_en_reg <= alert_en_next;
			if (cfg_wr) begin
				run_reg  <= i_reg_wdata[CFG_RUN_BIT];
				rate_reg <= wr_rate;
				tc_reg   <= i_reg_wdata[CFG_TC_BIT];
				comp_reg <= i_reg_wdata[CFG_COMP_BIT];
			end
			if (mask_wr) begin
				mask_en_reg <= i_reg_wdata[MASK_EN_LSB +: 7];
			end
		end
	end

	irsc_conv_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_sw_rst  (sw_rst),
		.i_run     (run_reg),
		.i_restart (restart),
		.i_rate    (rate_reg),
		.o_done    (conv_done),
		.o_busy    (o_converting)
	);

	// Results land first; flags look one cycle later
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sample_reg <= '0;
			eval_reg   <= 1'b0;
		end else if (sw_rst) begin
			sample_reg <= '0;
			eval_reg   <= 1'b0;
		end else begin
			eval_reg <= conv_done;
			if (conv_done) begin
				sample_reg <= i_sample;
			end
		end
	end

	// Limits are 0.5 C steps; results 1/32 C, so align by four bits
	function automatic logic [13:0] lim14(input logic [9:0] lim);
		lim14 = {lim, 4'h0};
	endfunction

	irsc_hits_s hits;
	assign hits.obj_hi           = $signed(sample_reg.object_temperature_result) > $signed(lim14(i_limits.obj_hi));
	assign hits.obj_lo           = $signed(sample_reg.object_temperature_result) < $signed(lim14(i_limits.obj_lo));
	assign hits.die_hi           = $signed(sample_reg.tdie) > $signed(lim14(i_limits.die_hi));
	assign hits.die_lo           = $signed(sample_reg.tdie) < $signed(lim14(i_limits.die_lo));
	assign hits.die_below_obj_lo = $signed(sample_reg.tdie) < $signed(lim14(i_limits.obj_lo));
	assign hits.invalid          = sample_reg.math_invalid;
	assign hits.over_range       = sample_reg.sensor_ovr;

	// Low-limit enables read as zero in compare mode
	wire logic [6:0] en_eff = {mask_en_reg[6:5], mask_en_reg[4] & ~comp_reg, mask_en_reg[3],
	                           mask_en_reg[2] & ~comp_reg, mask_en_reg[1:0]};

	irsc_flags u_flags (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_sw_rst    (sw_rst),
		.i_eval      (eval_reg),
		.i_comp      (comp_reg),
		.i_status_rd (status_rd),
		.i_cfg_wr    (cfg_wr),
		.i_result_rd (result_rd),
		.i_hits      (hits),
		.i_mem_done  (i_mem_check_done),
		.i_mem_fail  (i_mem_check_fail),
		.i_en        ({en_eff, en_eff[1]}),
		.o_flags     (flags),
		.o_cumulative_alert_flag     (cumulative_alert_flag)
	);

	// Read words
	wire logic [15:0] cfg_word = {3'h0, run_reg, rate_reg, alert_en_reg, cumulative_alert_flag, tc_reg, comp_reg, 5'h00};
	wire logic [15:0] status_word = {cumulative_alert_flag, flags, 7'h00};
	wire logic [15:0] mask_word = {alert_en_reg, en_eff, 8'h00};
	wire logic [15:0] object_temperature_result_word = {sample_reg.object_temperature_result, 1'b0, sample_reg.math_invalid};
	wire logic [15:0] tdie_word = {sample_reg.tdie, 2'h0};

	wire logic [15:0] rd_mux = (i_reg_addr == ADDR_VSENSOR) ? sample_reg.vsensor
	                         : (i_reg_addr == ADDR_TDIE)    ? tdie_word
	                         : (i_reg_addr == ADDR_CFG)     ? cfg_word
	                         : (i_reg_addr == ADDR_OBJECT_TEMPERATURE_RESULT)    ? object_temperature_result_word
	                         : (i_reg_addr == ADDR_STATUS)  ? status_word
	                         : (i_reg_addr == ADDR_MASK)    ? mask_word
	                         : 16'h0000;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata      <= 16'h0000;
			o_reg_rvalid     <= 1'b0;
			o_alert_n        <= 1'b1;
			o_conv_restart   <= 1'b0;
			o_avg_count      <= avg_of(CFG_RST_VAL[CFG_RATE_LSB +: 3]);
			o_transient_corr <= CFG_RST_VAL[CFG_TC_BIT];
		end else begin
			o_reg_rvalid     <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rd_mux;
			end
			o_alert_n        <= ~(alert_en_reg & cumulative_alert_flag);
			o_conv_restart   <= restart | sw_rst;
			o_avg_count      <= avg_of(rate_reg);
			o_transient_corr <= tc_reg;
		end
	end
endmodule // irsc_top

/* irsc_checker_properties.sv */
module irsc_checker #(
	parameter int unsigned CYC_PER_MS = irsc_pkg::CYC_PER_MS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [15:0] i_reg_wdata,
	input  wire logic        o_reg_rvalid,
	input  wire logic        o_alert_n,
	input  wire logic        o_conv_restart,
	input  wire logic [4:0]  o_avg_count,
	input  wire logic        o_transient_corr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic aen_reg;
	wire  is_cfg_wr = i_reg_wr && i_reg_addr == 8'h02;
	// Shadow of the shared alert enable, fed from both register views
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			aen_reg <= 1'b0;
		else if (is_cfg_wr)
			aen_reg <= i_reg_wdata[15] ? 1'b0 : i_reg_wdata[8];
		else if (i_reg_wr && i_reg_addr == 8'h05)
			aen_reg <= i_reg_wdata[15];
	end
	a_read_answered: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
	a_no_stray_valid: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray read valid");
	a_run_write_restarts: assert property (
		is_cfg_wr && !i_reg_wdata[15] && i_reg_wdata[12] |=> o_conv_restart) else $error("no restart");
	a_quiet_no_restart: assert property (
		i_reg_wr && !(is_cfg_wr && (i_reg_wdata[15] || i_reg_wdata[12])) |=> !o_conv_restart)
		else $error("unexpected restart");
	a_soft_reset_defaults: assert property (
		is_cfg_wr && i_reg_wdata[15] ##1 !i_reg_wr |-> o_conv_restart ##1 (o_avg_count == 5'h04 && o_transient_corr))
		else $error("soft reset not applied");
	a_avg_from_rate: assert property (
		is_cfg_wr && !i_reg_wdata[15] ##1 !i_reg_wr |=> o_avg_count == (5'h01 << ($past(i_reg_wdata[11:9], 2) % 3'd5)))
		else $error("average count wrong");
	a_tc_from_bit: assert property (
		is_cfg_wr && !i_reg_wdata[15] ##1 !i_reg_wr |=> o_transient_corr == $past(i_reg_wdata[6], 2))
		else $error("transient correction wrong");
	a_alert_off_high: assert property (!aen_reg && !$past(aen_reg) |-> o_alert_n) else $error("alert driven");
endmodule // irsc_checker

bind irsc_top irsc_checker #(.CYC_PER_MS(CYC_PER_MS)) u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid), .o_alert_n(o_alert_n),
	.o_conv_restart(o_conv_restart), .o_avg_count(o_avg_count), .o_transient_corr(o_transient_corr));

/* irsc_host_model.sv */
module irsc_host_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_wr,
	output logic             o_rd,
	output logic [7:0]       o_addr,
	output logic [15:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 16'h0000;
	end
	// One-cycle strobe; released lines show inverted data so stale values never match
	task automatic put(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		put(1'b1, a, d);
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		put(1'b0, a, 16'h0000);
		@(posedge i_clk);
		d = i_rvalid ? i_rdata : 16'hxxxx;
	endtask
endmodule // irsc_host_model

/* test_ir_sensor_config_status_alert.sv */
module test_ir_sensor_config_status_alert;
	timeunit 1ns;
	timeprecision 1ps;
	import irsc_pkg::*;
	logic clk, rst, wr, rd, mem_done, mem_fail, rvalid, alert_n, converting, restart, tc, ovr1;
	logic [7:0]    addr;
	logic [15:0]   wdata, rdata, rd_v;
	logic [4:0]    avg;
	logic [13:0]   object_temperature_result_v;
	irsc_sample_s  sample;
	irsc_limits_s  limits;
	int            bad_count, cmp_count, cyc_count;
	irsc_top #(.CYC_PER_MS(10)) u_dut (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_sample(sample), .i_limits(limits),
		.i_mem_check_done(mem_done), .i_mem_check_fail(mem_fail), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .o_alert_n(alert_n), .o_converting(converting),
		.o_conv_restart(restart), .o_avg_count(avg), .o_transient_corr(tc));
	irsc_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run;
		$display("mismatches %0d of %0d compares", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_count++;
		if (cyc_count == 40000) begin
			bad_count++;
			complete_run;
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		u_host.read_reg(a, rd_v);
		check(rd_v, exp);
	endtask
	function automatic logic [4:0] exp_avg(input logic [2:0] r);
		return 5'h01 << (r > 3'd4 ? r - 3'd5 : r);
	endfunction
	// Half-step offsets keep results clear of limit equality
	task automatic set_sample(input logic viol, input logic inv, input logic ovr);
		logic [9:0] t10, d10;
		t10 = 10'($urandom_range(200)) - 10'd100;
		d10 = t10 - 10'd3;
		object_temperature_result_v = {t10, 4'h8};
		@(posedge clk);
		sample <= {16'($urandom), d10, 4'h8, t10, 4'h8, inv, ovr};
		limits <= viol ? {t10 - 10'd1, t10 + 10'd1, d10 - 10'd1, d10 + 10'd1}
			: {t10 + 10'd1, t10 - 10'd1, d10 + 10'd1, d10 - 10'd1};
	endtask
	// Active part of rate code 000 at the reduced scale is 2600 cycles
	task automatic conv_wait;
		repeat (2610) @(posedge clk);
	endtask
	task automatic mem_pulse(input logic f);
		@(posedge clk);
		mem_done <= 1'b1;
		mem_fail <= f;
		@(posedge clk);
		mem_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		sample = '0;
		limits = '0;
		mem_done = 1'b0;
		mem_fail = 1'b0;
		void'($urandom(32'h2b2604e4));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h02, 16'h1440);
		rd_chk(8'h03, 16'h0000);
		rd_chk(8'h04, 16'h0000);
		rd_chk(8'h07, 16'h0000);
		u_host.write_reg(8'h05, 16'hff00);
		rd_chk(8'h02, 16'h1540);
		ovr1 = 1'($urandom);
		set_sample(1'b1, 1'b1, ovr1);
		u_host.write_reg(8'h02, 16'h1140);
		conv_wait;
		check({15'h0, alert_n}, 16'h0000);
		rd_chk(8'h03, {object_temperature_result_v, 2'b01});
		set_sample(1'b0, 1'b0, 1'b0);
		conv_wait;
		rd_chk(8'h03, {object_temperature_result_v, 2'b00});
		rd_chk(8'h04, {6'h2f, 1'b1, 1'b0, ovr1, 7'h00});
		rd_chk(8'h04, 16'h0000);
		repeat (4) @(posedge clk);
		check({15'h0, alert_n}, 16'h0001);
		u_host.write_reg(8'h05, 16'hbf00);
		rd_chk(8'h05, 16'hbf00);
		set_sample(1'b1, 1'($urandom), 1'b1);
		u_host.write_reg(8'h02, 16'h1160);
		rd_chk(8'h05, 16'hab00);
		conv_wait;
		check({15'h0, alert_n}, 16'h0000);
		set_sample(1'b0, 1'b0, 1'b0);
		rd_chk(8'h04, 16'hea80);
		conv_wait;
		rd_chk(8'h04, 16'h4000);
		check({15'h0, alert_n}, 16'h0001);
		u_host.write_reg(8'h05, 16'h0000);
		u_host.write_reg(8'h02, 16'h0000);
		u_host.read_reg(8'h04, rd_v);
		conv_wait;
		check({15'h0, converting}, 16'h0000);
		rd_chk(8'h04, 16'h0000);
		mem_pulse(1'b1);
		rd_chk(8'h04, 16'h0100);
		rd_chk(8'h04, 16'h0100);
		mem_pulse(1'b0);
		rd_chk(8'h04, 16'h0000);
		for (int r = 0; r < 8; r++) begin
			ovr1 = 1'($urandom);
			u_host.write_reg(8'h02, 16'h1000 | (16'(r) << 9) | (16'(ovr1) << 6));
			repeat (3) @(posedge clk);
			check({11'h0, avg}, {11'h0, exp_avg(3'(r))});
			check({15'h0, tc}, {15'h0, ovr1});
		end
		u_host.write_reg(8'h05, 16'h8000);
		u_host.write_reg(8'h02, 16'h8000);
		rd_chk(8'h02, 16'h1440);
		rd_chk(8'h05, 16'h0000);
		rd_chk(8'h03, 16'h0000);
		complete_run;
	end
endmodule // test_ir_sensor_config_status_alert
